// ---- psc_pkg.sv ----
// Purpose: shared constants for the per-port statistics counter block
// Assumes: one instance per Ethernet port, 250 MHz system clock
// Notes: counter word indices are kept as indices; byte address is index times four
package psc_pkg;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int NUM_CNT = 30;
    localparam int NUM_WORDS = 16;
    localparam int LEN_W = 16;
    localparam int WORD_W = 32;

    // ------------------------------------------------------------
    // frame length and collision limits
    // ------------------------------------------------------------
    localparam logic [15:0] LEN_SHORT = 16'h000A;
    localparam logic [15:0] LEN_MIN = 16'h0040;
    localparam logic [15:0] LEN_MAX_UNTAG = 16'h05EE;
    localparam logic [15:0] LEN_MAX_TAG = 16'h05F2;
    localparam logic [15:0] LEN_127 = 16'h007F;
    localparam logic [15:0] LEN_255 = 16'h00FF;
    localparam logic [15:0] LEN_511 = 16'h01FF;
    localparam logic [15:0] LEN_1023 = 16'h03FF;
    localparam logic [15:0] LEN_1528 = 16'h05F8;
    localparam logic [4:0] COLL_LIMIT = 5'h10;

    // ------------------------------------------------------------
    // wrap flag positions in the status word
    // ------------------------------------------------------------
    localparam int WB_TX_BYTES = 0;
    localparam int WB_TX_UCAST = 1;
    localparam int WB_TX_FAIL = 2;
    localparam int WB_TX_PAUSE = 3;
    localparam int WB_TX_NUCAST = 4;
    localparam int WB_RX_BYTES = 5;
    localparam int WB_RX_FRAMES = 6;
    localparam int WB_GOOD_OCTET = 7;
    localparam int WB_GOOD_FRAMES = 8;
    localparam int WB_RX_PAUSE = 9;
    localparam int WB_RX_MCAST = 10;
    localparam int WB_RX_BCAST = 11;
    localparam int WB_LEN64 = 12;
    localparam int WB_JABBER = 13;
    localparam int WB_LEN127 = 14;
    localparam int WB_OVERSIZE = 15;
    localparam int WB_LEN255 = 16;
    localparam int WB_LEN511 = 17;
    localparam int WB_LEN1023 = 18;
    localparam int WB_LEN1528 = 19;
    localparam int WB_FRAGMENT = 20;
    localparam int WB_ALIGN = 21;
    localparam int WB_UNDERSIZE = 22;
    localparam int WB_CRC = 23;
    localparam int WB_SHORT = 24;
    localparam int WB_COLLISION = 25;
    localparam int WB_DROP = 26;
    localparam int WB_FILTER = 27;
    localparam int WB_DELAY = 28;
    localparam int WB_LATE_COLL = 29;
    localparam int OTHER_STAT_W = 2;

    // ------------------------------------------------------------
    // counter placement: word index, low bit, width
    // ------------------------------------------------------------
    localparam int CNT_WORD [NUM_CNT] = '{0, 1, 1, 2, 2, 3, 4, 5, 6, 6, 7, 7, 8, 8, 9,
        9, 10, 10, 11, 11, 12, 12, 12, 13, 13, 14, 14, 15, 15, 15};
    localparam int CNT_LSB [NUM_CNT] = '{0, 0, 24, 0, 16, 0, 0, 0, 0, 24, 0, 16, 0, 24, 0,
        24, 0, 16, 0, 16, 0, 16, 24, 0, 16, 0, 16, 0, 16, 24};
    localparam int CNT_WID [NUM_CNT] = '{32, 24, 8, 16, 16, 32, 32, 32, 24, 8, 16, 16, 24, 8,
        24, 8, 16, 16, 16, 16, 16, 8, 8, 16, 16, 16, 16, 16, 8, 8};

    // ------------------------------------------------------------
    // apb map
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CNT_LAST = 8'h3C;
    localparam logic [7:0] REG_WRAP_STAT = 8'h40;
    localparam logic [7:0] REG_WRAP_MASK = 8'h44;
    localparam logic [7:0] REG_WRAP_WORD = 8'h48;
    localparam logic [29:0] MASK_RST = 30'h00000000;

endpackage

// ---- psc_port_statistics_counters.sv ----
// Purpose: per-port statistics counters with wrap reporting and apb read-out
// Assumes: event inputs are one-cycle pulses synchronous to clock
// Notes: counters sit in a 16-word flop memory read at byte address index*4
//
// What this block does
// [R1] keep every statistics counter of the port and let the host read them over apb.
// [R2] every counter wraps on overflow rather than saturating: counts restart at zero, byte totals keep the excess.
// [R3] any counter wrap raises the host interrupt through sticky status and mask.
// [R4] wraps are sent as a status word with flags in bits 29:0 and other status above.
// [R5] flags 0 to 4 are bytes sent, unicast sent, send fail, pause sent, non-unicast sent.
// [R6] flags 5 to 11 are rx bytes, rx frames, good bytes, good frames, pause, multicast, broadcast.
// [R7] length flags are 12 for 64, 14, 16, 17, 18 and 19 for the larger buckets up to 1528.
// [R8] error flags are 13 jabber, 15 oversize, 20 to 26 fragment to drop, and 29 late collision.
// [R9] filtering discards come from the queue manager and delay discards from the buffer manager.
// [R10] each counter has a fixed word in counter memory, byte totals take a whole word.
// [R11] 24/8 splits use 23:0 and 31:24, 16/8/8 splits use 15:0, 23:16 and 31:24.
// [R12] 16/16 splits use 15:0 and 31:16.
// [R13] the good octet count adds lengths of error-free frames from 64 to 1518 or 1522 tagged.
// [R14] send fail counts underruns, late collisions and a frame's sixteenth collision.
// [R15] the non-unicast sent count takes every sent broadcast or multicast frame.
// [R16] each overflow pulses its wrap flag once, and all counters clear at reset.
`timescale 1ns/1ps
`default_nettype none

module psc_port_statistics_counters
    import psc_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rx_done,
    input wire logic [15:0] rx_len,
    input wire logic rx_tagged,
    input wire logic rx_fcs_err,
    input wire logic rx_align_err,
    input wire logic rx_collision,
    input wire logic rx_pause,
    input wire logic rx_mcast,
    input wire logic rx_bcast,
    input wire logic rx_drop,
    input wire logic tx_done,
    input wire logic [15:0] tx_len,
    input wire logic tx_pause,
    input wire logic tx_mcast,
    input wire logic tx_bcast,
    input wire logic tx_collision,
    input wire logic tx_late_coll,
    input wire logic tx_underrun,
    input wire logic qm_filter_discard,
    input wire logic bm_delay_discard,
    output logic [31:0] wrap_word,
    output logic wrap_word_valid,
    output logic irq
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [31:0] mem_ff [NUM_WORDS];
    logic [31:0] nxt_mem [NUM_WORDS];
    logic [4:0] attempt_ff;
    logic [4:0] nxt_attempt;
    logic [29:0] stat_ff;
    logic [29:0] nxt_stat;
    logic [29:0] mask_ff;
    logic [29:0] nxt_mask;
    logic [31:0] word_ff;
    logic [31:0] nxt_word;
    logic valid_ff;
    logic nxt_valid;
    logic [31:0] prdata_ff;
    logic [31:0] nxt_prdata;

    logic [NUM_CNT-1:0] ev;
    logic [NUM_CNT-1:0] wrap;
    logic [15:0] inc [NUM_CNT];
    logic [31:0] cnt_new [NUM_CNT];
    logic [31:0] cnt_mask [NUM_CNT];

    // ------------------------------------------------------------
    // receive classification and transmit fail detection
    // ------------------------------------------------------------
    logic [15:0] rx_max;
    logic size_ok;
    logic too_long;
    logic too_short;
    logic rx_good;
    logic tx_excess;
    logic tx_fail;

    assign rx_max = rx_tagged ? LEN_MAX_TAG : LEN_MAX_UNTAG;
    assign size_ok = (rx_len >= LEN_MIN) && (rx_len <= rx_max);
    assign too_long = rx_len > rx_max;
    assign too_short = rx_len < LEN_MIN;
    // [R13] good frame test
    assign rx_good = size_ok && !rx_fcs_err && !rx_align_err && !rx_collision;

    // [R14] sixteenth collision of one frame
    assign tx_excess = tx_collision && (attempt_ff == COLL_LIMIT - 5'h01);
    // [R14] send fail sources
    assign tx_fail = tx_underrun || tx_late_coll || tx_excess;

    always_comb begin
        nxt_attempt = attempt_ff;
        if (tx_done || tx_excess) begin
            nxt_attempt = 5'h00;
        end else if (tx_collision) begin
            nxt_attempt = attempt_ff + 5'h01;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            attempt_ff <= 5'h00;
        end else begin
            attempt_ff <= nxt_attempt;
        end
    end

    // ------------------------------------------------------------
    // event vector, one bit per counter
    // ------------------------------------------------------------
    always_comb begin
        ev = '0;
        // [R5] transmit counters
        ev[WB_TX_BYTES] = tx_done;
        ev[WB_TX_UCAST] = tx_done && !tx_mcast && !tx_bcast;
        ev[WB_TX_FAIL] = tx_fail;
        ev[WB_TX_PAUSE] = tx_done && tx_pause;
        // [R15] broadcast or multicast sent
        ev[WB_TX_NUCAST] = tx_done && (tx_mcast || tx_bcast);
        // [R6] receive counters
        ev[WB_RX_BYTES] = rx_done;
        ev[WB_RX_FRAMES] = rx_done;
        ev[WB_GOOD_OCTET] = rx_done && rx_good;
        ev[WB_GOOD_FRAMES] = rx_done && rx_good;
        ev[WB_RX_PAUSE] = rx_done && rx_good && rx_pause;
        ev[WB_RX_MCAST] = rx_done && rx_good && rx_mcast && !rx_bcast;
        ev[WB_RX_BCAST] = rx_done && rx_good && rx_bcast;
        // [R7] length buckets, good and bad frames alike
        ev[WB_LEN64] = rx_done && (rx_len == LEN_MIN);
        ev[WB_LEN127] = rx_done && (rx_len > LEN_MIN) && (rx_len <= LEN_127);
        ev[WB_LEN255] = rx_done && (rx_len > LEN_127) && (rx_len <= LEN_255);
        ev[WB_LEN511] = rx_done && (rx_len > LEN_255) && (rx_len <= LEN_511);
        ev[WB_LEN1023] = rx_done && (rx_len > LEN_511) && (rx_len <= LEN_1023);
        ev[WB_LEN1528] = rx_done && (rx_len > LEN_1023) && (rx_len <= LEN_1528);
        // [R8] receive error counters
        ev[WB_JABBER] = rx_done && too_long && rx_fcs_err && !rx_collision;
        ev[WB_OVERSIZE] = rx_done && too_long && !rx_collision;
        ev[WB_FRAGMENT] = rx_done && too_short && rx_fcs_err && !rx_collision;
        ev[WB_ALIGN] = rx_done && size_ok && rx_align_err && !rx_collision;
        ev[WB_UNDERSIZE] = rx_done && too_short && !rx_fcs_err && !rx_align_err
            && !rx_collision;
        ev[WB_CRC] = rx_done && size_ok && rx_fcs_err && !rx_collision;
        ev[WB_SHORT] = rx_done && (rx_len < LEN_SHORT) && !rx_collision;
        // the collision counter takes tx_collision only, late collisions count on their own
        ev[WB_COLLISION] = tx_collision;
        ev[WB_DROP] = rx_drop;
        // [R9] discards from the queue and buffer managers
        ev[WB_FILTER] = qm_filter_discard;
        ev[WB_DELAY] = bm_delay_discard;
        ev[WB_LATE_COLL] = tx_late_coll;
    end

    // ------------------------------------------------------------
    // per-counter add and wrap
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CNT; gi++) begin : g_cnt
            logic [32:0] mask33;
            logic [31:0] field;
            logic [32:0] sum;
            assign mask33 = (33'h000000001 << CNT_WID[gi]) - 33'h000000001;
            assign cnt_mask[gi] = mask33[31:0];
            // [R10] fixed word per counter
            // [R11] [R12] field taken by its low bit and width
            assign field = (mem_ff[CNT_WORD[gi]] >> CNT_LSB[gi]) & cnt_mask[gi];
            // byte totals add the frame length, the rest add one
            if (gi == WB_TX_BYTES) begin : g_txb
                assign inc[gi] = tx_len;
            end else if (gi == WB_RX_BYTES || gi == WB_GOOD_OCTET) begin : g_rxb
                // [R13] good octet count adds the frame length
                assign inc[gi] = rx_len;
            end else begin : g_one
                assign inc[gi] = 16'h0001;
            end
            assign sum = {1'b0, field} + {17'h00000, inc[gi]};
            // [R2] drop the carry so the field rolls over
            assign cnt_new[gi] = sum[31:0] & cnt_mask[gi];
            // [R16] one pulse per overflow
            assign wrap[gi] = ev[gi] && sum[CNT_WID[gi]];
        end
    endgenerate

    // ------------------------------------------------------------
    // counter memory
    // ------------------------------------------------------------
    always_comb begin
        for (int w = 0; w < NUM_WORDS; w++) begin
            nxt_mem[w] = mem_ff[w];
        end
        for (int i = 0; i < NUM_CNT; i++) begin
            if (ev[i]) begin
                nxt_mem[CNT_WORD[i]] = (nxt_mem[CNT_WORD[i]] & ~(cnt_mask[i] << CNT_LSB[i]))
                    | (cnt_new[i] << CNT_LSB[i]);
            end
        end
    end

    always_ff @(posedge clock) begin
        for (int w = 0; w < NUM_WORDS; w++) begin
            // [R16] counters clear at reset
            if (rst) begin
                mem_ff[w] <= 32'h00000000;
            end else begin
                mem_ff[w] <= nxt_mem[w];
            end
        end
    end

    // ------------------------------------------------------------
    // wrap status word to the command block
    // ------------------------------------------------------------
    always_comb begin
        // [R4] flags low, other status bits above stay clear
        nxt_word = word_ff;
        nxt_valid = |wrap;
        if (|wrap) begin
            nxt_word = {{OTHER_STAT_W{1'b0}}, wrap};
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            word_ff <= 32'h00000000;
            valid_ff <= 1'b0;
        end else begin
            word_ff <= nxt_word;
            valid_ff <= nxt_valid;
        end
    end

    assign wrap_word = word_ff;
    assign wrap_word_valid = valid_ff;

    // ------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------
    logic setup;
    logic access;
    logic mapped;
    logic wr_stat;

    assign setup = psel && !penable;
    assign access = psel && penable;
    assign mapped = (paddr[1:0] == 2'h0) && (paddr <= REG_WRAP_WORD);
    assign wr_stat = access && pwrite && (paddr == REG_WRAP_STAT);

    // read data captured in setup so prdata comes from a flop; no wait states
    always_comb begin
        nxt_prdata = prdata_ff;
        if (setup && !pwrite) begin
            // unmapped reads give zero, misaligned low addresses too
            if (!mapped) begin
                nxt_prdata = 32'h00000000;
            end else if (paddr <= REG_CNT_LAST) begin
                // [R1] counter words readable by the host
                nxt_prdata = mem_ff[paddr[5:2]];
            end else if (paddr == REG_WRAP_STAT) begin
                nxt_prdata = {{OTHER_STAT_W{1'b0}}, stat_ff};
            end else if (paddr == REG_WRAP_MASK) begin
                nxt_prdata = {{OTHER_STAT_W{1'b0}}, mask_ff};
            end else if (paddr == REG_WRAP_WORD) begin
                nxt_prdata = word_ff;
            end else begin
                nxt_prdata = 32'h00000000;
            end
        end
    end

    // ------------------------------------------------------------
    // interrupt status and mask
    // ------------------------------------------------------------
    always_comb begin
        nxt_mask = mask_ff;
        nxt_stat = stat_ff;
        if (access && pwrite && (paddr == REG_WRAP_MASK)) begin
            nxt_mask = pwdata[29:0];
        end
        if (wr_stat) begin
            nxt_stat = stat_ff & ~pwdata[29:0];
        end
        // [R3] a new wrap wins over a clear in the same cycle
        nxt_stat = nxt_stat | wrap;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            prdata_ff <= 32'h00000000;
            mask_ff <= MASK_RST;
            stat_ff <= 30'h00000000;
        end else begin
            prdata_ff <= nxt_prdata;
            mask_ff <= nxt_mask;
            stat_ff <= nxt_stat;
        end
    end

    assign prdata = prdata_ff;
    assign pready = access;
    assign pslverr = access && !mapped;
    // [R3] level interrupt while an enabled wrap is pending
    assign irq = |(stat_ff & mask_ff);

endmodule

`default_nettype wire

// ---- psc_checker_assertions.sv ----
// Purpose: port-level checks of the statistics counter block
// Assumes: one clock domain, synchronous active-high reset
// Notes: attached by bind below the module
`timescale 1ns/1ps
`default_nettype none

module psc_checker
    import psc_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic rx_done,
    input wire logic tx_done,
    input wire logic tx_collision,
    input wire logic tx_late_coll,
    input wire logic tx_underrun,
    input wire logic rx_drop,
    input wire logic qm_filter_discard,
    input wire logic bm_delay_discard,
    input wire logic [31:0] wrap_word,
    input wire logic wrap_word_valid,
    input wire logic irq
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    logic ev;
    logic cfg_wr;
    assign ev = rx_done | tx_done | tx_collision | tx_late_coll | tx_underrun | rx_drop
        | qm_filter_discard | bm_delay_discard;
    // only status and mask writes may move irq by themselves
    assign cfg_wr = psel & penable & pwrite & (paddr == REG_WRAP_STAT | paddr == REG_WRAP_MASK);
    sequence s_acc;
        psel && penable;
    endsequence
    sequence s_bad;
        s_acc ##0 (paddr > REG_WRAP_WORD || paddr[1:0] != 2'h0);
    endsequence
    // ----------------------------------------
    // register bus
    // ----------------------------------------
    a_ready_access: assert property (s_acc |-> pready)
        else $error("pready low in an access cycle");
    a_err_unmapped: assert property (s_bad |-> pslverr)
        else $error("unmapped access without pslverr");
    a_err_mapped: assert property (s_acc ##0 paddr <= REG_WRAP_WORD && paddr[1:0] == 2'h0
        |-> !pslverr) else $error("mapped access with pslverr");
    a_err_rdata: assert property (s_bad ##0 !pwrite |-> prdata == 32'h0)
        else $error("unmapped read returned data");
    a_rdata_hold: assert property ($past(psel && penable) |-> $stable(prdata))
        else $error("read data moved after an access cycle");
    // ----------------------------------------
    // wrap reporting
    // ----------------------------------------
    a_wrap_format: assert property (wrap_word_valid |-> wrap_word[31:30] == 2'h0
        && wrap_word[29:0] != 30'h0) else $error("bad wrap word");
    a_wrap_cause: assert property (wrap_word_valid |-> $past(ev))
        else $error("wrap pulse without a counted event");
    a_wrap_hold: assert property (!wrap_word_valid |-> $stable(wrap_word))
        else $error("wrap word moved without valid");
    a_irq_rise: assert property ($rose(irq) |-> wrap_word_valid || $past(cfg_wr))
        else $error("irq rose without a wrap");
    a_irq_fall: assert property ($fell(irq) |-> $past(cfg_wr))
        else $error("irq fell without a status or mask write");
endmodule

bind psc_port_statistics_counters psc_checker u_chk (.clock, .rst, .psel, .penable, .pwrite,
    .paddr, .prdata, .pready, .pslverr, .rx_done, .tx_done, .tx_collision, .tx_late_coll,
    .tx_underrun, .rx_drop, .qm_filter_discard, .bm_delay_discard, .wrap_word,
    .wrap_word_valid, .irq);
`default_nettype wire

// ---- psc_host_model.sv ----
// Purpose: host processor model, apb master reading the counters
// Assumes: slave may add wait states; bench timeout ends a hang
// Notes: released address and data lines show the inverse value
`timescale 1ns/1ps
`default_nettype none

module psc_host_model (
    input wire logic clock,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial begin
        {psel, penable, pwrite} = 3'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic e);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule
`default_nettype wire

// ---- tb_port_statistics_counters.sv ----
// Purpose: self-checking bench of the statistics counter block
// Assumes: host model speaks apb, bench drives event pulses
// Notes: fixed seed keeps the random frames repeatable
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin total_checks++; if ((gt) !== (ex)) begin miscompares++; \
    $display("BAD %s exp=%h got=%h", nm, ex, gt); end end

module tb_port_statistics_counters
    import psc_pkg::*;
();
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic psel, penable, pwrite, pready, pslverr, wrap_word_valid, irq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, wrap_word;
    logic rx_done = 1'b0, rx_tagged = 1'b0, rx_pause = 1'b0, rx_mcast = 1'b0, rx_bcast = 1'b0;
    logic rx_fcs_err = 1'b0, rx_align_err = 1'b0, rx_collision = 1'b0;
    logic tx_done = 1'b0, tx_pause = 1'b0, tx_mcast = 1'b0, tx_bcast = 1'b0;
    logic [15:0] rx_len = 16'h0, tx_len = 16'h0;
    // pulse sources: underrun, collision, late, filter, delay, drop
    logic [5:0] pv = 6'h0;
    int miscompares = 0;
    int total_checks = 0;
    int cycles = 0;
    logic [31:0] seed = 32'h40eaafe8;
    logic [31:0] e_txb = 32'h0, e_uc = 32'h0, e_nu = 32'h0, e_tp = 32'h0, e_rxb = 32'h0;
    logic [31:0] e_rxf = 32'h0, e_gb = 32'h0, e_gf = 32'h0, e_64 = 32'h0;
    logic [31:0] e_w7 = 32'h0, e_w9 = 32'h0, e_w13 = 32'h0;
    logic [15:0] lens [8] = '{16'h0040, 16'h003F, 16'h05EE, 16'h05EF, 16'h05F2, 16'h05F3,
        16'h0041, 16'h0040};

    psc_port_statistics_counters u_dut (.clock, .rst, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .rx_done, .rx_len, .rx_tagged, .rx_fcs_err,
        .rx_align_err, .rx_collision, .rx_pause, .rx_mcast, .rx_bcast, .rx_drop(pv[5]),
        .tx_done, .tx_len, .tx_pause, .tx_mcast, .tx_bcast, .tx_collision(pv[1]),
        .tx_late_coll(pv[2]), .tx_underrun(pv[0]), .qm_filter_discard(pv[3]),
        .bm_delay_discard(pv[4]), .wrap_word, .wrap_word_valid, .irq);
    psc_host_model u_host (.clock, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr);

    initial begin
        forever #2 clock = ~clock;
    end
    // long enough for every test with a wide margin
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            summarize();
        end
    end

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic good(input logic [15:0] l, input logic t, input logic [2:0] er);
        return l >= LEN_MIN && l <= (t ? LEN_MAX_TAG : LEN_MAX_UNTAG) && er == 3'h0;
    endfunction
    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] x,
        input logic [31:0] m);
        logic [31:0] q;
        logic e;
        u_host.xfer(1'b0, a, 32'h0, q, e);
        `CHK(nm, x & m, q & m)
        `CHK("pslverr", 1'b0, e)
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        u_host.xfer(1'b1, a, d, q, e);
    endtask
    // sources held high n cycles count n times
    task automatic hold(input logic [5:0] m, input int n);
        @(posedge clock);
        pv <= m;
        repeat (n) @(posedge clock);
        pv <= 6'h0;
    endtask
    task automatic summarize();
        $display("checks=%0d mismatches=%0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        logic [31:0] r;
        logic [31:0] q;
        logic [15:0] ln;
        logic [15:0] mx;
        logic [2:0] er;
        logic e;
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        for (int k = 0; k < 19; k++) rdc("reset", 8'(4 * k), 32'h0, 32'hFFFFFFFF);
        $display("test reset done");
        for (int i = 0; i < 40; i++) begin
            ln = (i < 8) ? lens[i] : 16'($random(seed) & 32'h7FF);
            r = $random(seed);
            er = r[3:1] & r[6:4];
            mx = r[0] ? LEN_MAX_TAG : LEN_MAX_UNTAG;
            @(posedge clock);
            {rx_done, tx_done, rx_len, tx_len, rx_tagged} <= {2'h3, ln, ln, r[0]};
            {rx_fcs_err, rx_align_err, rx_collision} <= er;
            {tx_mcast, tx_bcast, tx_pause} <= {r[7], r[8], r[9] & r[7]};
            {rx_pause, rx_mcast, rx_bcast} <= r[13:11];
            e_txb += ln;
            e_uc += !(r[7] | r[8]);
            e_nu += r[7] | r[8];
            e_tp += r[9] & r[7];
            e_rxb += ln;
            e_rxf += 1;
            e_gb += good(ln, r[0], er) ? ln : 16'h0;
            e_gf += good(ln, r[0], er);
            e_64 += (ln == 16'h0040);
            e_w7 += good(ln, r[0], er) ? {15'h0, r[11], 15'h0, r[12] & !r[11]} : 32'h0;
            e_w9 += {7'h0, ln > mx && !er[0], 23'h0, ln > LEN_MIN && ln <= LEN_127};
            e_w13 += {15'h0, ln < LEN_SHORT && !er[0], 15'h0,
                er[2] && !er[0] && ln >= LEN_MIN && ln <= mx};
        end
        @(posedge clock);
        {rx_done, tx_done} <= 2'h0;
        rdc("tx_bytes", 8'h00, e_txb, 32'hFFFFFFFF);
        rdc("tx_ucast", 8'h04, {8'h0, e_uc[23:0]}, 32'hFFFFFFFF);
        rdc("tx_pause_nucast", 8'h08, {e_nu[15:0], e_tp[15:0]}, 32'hFFFFFFFF);
        rdc("rx_bytes", 8'h0C, e_rxb, 32'hFFFFFFFF);
        rdc("rx_frames", 8'h10, e_rxf, 32'hFFFFFFFF);
        rdc("good_octet_count", 8'h14, e_gb, 32'hFFFFFFFF);
        rdc("good_frames", 8'h18, e_gf, 32'h00FFFFFF);
        rdc("len64", 8'h20, e_64, 32'h00FFFFFF);
        rdc("mcast_bcast", 8'h1C, e_w7, 32'hFFFFFFFF);
        rdc("len127_oversize", 8'h24, e_w9, 32'hFFFFFFFF);
        rdc("crc_short", 8'h34, e_w13, 32'hFFFFFFFF);
        $display("test frames done");
        hold(6'h01, 255);
        rdc("fail_full", 8'h04, 32'hFF000000, 32'hFF000000);
        hold(6'h01, 1);
        #1;
        `CHK("wrap_valid", 1'b1, wrap_word_valid)
        `CHK("wrap_word", 32'h4, wrap_word)
        `CHK("irq_masked", 1'b0, irq)
        @(posedge clock);
        #1;
        `CHK("wrap_once", 1'b0, wrap_word_valid)
        rdc("fail_wrapped", 8'h04, 32'h0, 32'hFF000000);
        rdc("status", REG_WRAP_STAT, 32'h4, 32'hFFFFFFFF);
        wr(REG_WRAP_MASK, 32'h4);
        @(posedge clock);
        #1;
        `CHK("irq_on", 1'b1, irq)
        wr(REG_WRAP_STAT, 32'h4);
        @(posedge clock);
        #1;
        `CHK("irq_off", 1'b0, irq)
        rdc("status_clr", REG_WRAP_STAT, 32'h0, 32'hFFFFFFFF);
        rdc("last_wrap", REG_WRAP_WORD, 32'h4, 32'hFFFFFFFF);
        $display("test wrap done");
        hold(6'h02, 15);
        rdc("fail_15coll", 8'h04, 32'h0, 32'hFF000000);
        hold(6'h02, 1);
        rdc("fail_16coll", 8'h04, 32'h01000000, 32'hFF000000);
        hold(6'h06, 1);
        hold(6'h08, 3);
        hold(6'h10, 5);
        hold(6'h20, 2);
        rdc("fail_late", 8'h04, 32'h02000000, 32'hFF000000);
        rdc("coll_drop", 8'h38, {16'h2, 16'h11}, 32'hFFFFFFFF);
        rdc("filter_delay_late", 8'h3C, {8'h1, 8'h5, 16'h3}, 32'hFFFFFFFF);
        u_host.xfer(1'b0, 8'h4C, 32'h0, q, e);
        `CHK("unmapped_err", 1'b1, e)
        `CHK("unmapped_data", 32'h0, q)
        u_host.xfer(1'b1, 8'h45, 32'h0, q, e);
        `CHK("misaligned_err", 1'b1, e)
        u_host.xfer(1'b0, 8'h05, 32'h0, q, e);
        `CHK("misaligned_data", 32'h0, q)
        rdc("mask_kept", REG_WRAP_MASK, 32'h4, 32'hFFFFFFFF);
        $display("test sources done");
        summarize();
    end
endmodule
`default_nettype wire
